// ### verilog/pm_regs_pkg.sv
// Purpose: Constants for the power-management command register bank.
// Assumes: One clock, asynchronous active-low reset, byte-wide commands.
// Notes on behaviour
// - Select bit 7 all, bit 0 index.
// - Select pattern 10 is discarded, no change.
// - Both selected: reads return channel one.
// - Writes to read-only bits are discarded.
// - Operation mode held until command or pin.
// - Operation bit 7 enables; zero holds gates low when config bits 4 and 3 are set.
// - Margin field decodes off, low, high codes.
// - Channel 0 margin selects low or high target setting.
// - Config per channel with stated defaults.
// - Config bit 4 zero: start when powered.
// - Config bit 3 selects obeying enable bit.
// - Config bit 2 selects requiring control pin.
// - Polarity bit effective only after power cycle.
// - Config bit 0 reads fixed zero.
// - Clear faults clears page status, releases alert.
// - Clear faults never restarts latched-off channel.
// - Persisting fault sets bit again, alerts again.
// - Reads always succeed despite write guard.
// - Guard bit 5: only guard, select, operation, config.
// - Guard bit 6: only guard, select, operation.
// - Guard bit 7: only the guard itself.
// - Several guard bits: alert and communication fault.
// - Clear faults keeps unit-is-off indication.
`default_nettype none

package pm_regs_pkg;
  localparam logic [7:0] CMD_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] CMD_OUTPUT_COMMAND = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_GUARD = 8'h10;
  localparam int SEL_ALL_BIT = 7;
  localparam int SEL_IDX_BIT = 0;
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_HI = 5;
  localparam int OP_MARGIN_LO = 2;
  localparam logic [7:0] OP_WRITE_MASK = 8'hbc;
  localparam int CFG_PU_BIT = 4;
  localparam int CFG_CMD_BIT = 3;
  localparam int CFG_CPR_BIT = 2;
  localparam int CFG_POL_BIT = 1;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h1e;
  localparam logic [7:0] CFG_RESET = 8'h16;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [7:0] GUARD_WRITE_MASK = 8'he0;
  localparam int GUARD_CFG_BIT = 5;
  localparam int GUARD_OP_BIT = 6;
  localparam int GUARD_ALL_BIT = 7;
  localparam logic [3:0] MARGIN_LOW_IGN = 4'h5;
  localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
  localparam logic [3:0] MARGIN_HIGH_IGN = 4'h9;
  localparam logic [3:0] MARGIN_HIGH_ACT = 4'ha;
  typedef enum logic [1:0] {
    MARGIN_OFF = 2'h0,
    MARGIN_LOW = 2'h1,
    MARGIN_HIGH = 2'h2
  } margin_e;
endpackage : pm_regs_pkg

`default_nettype wire

// ### verilog/pm_channel.sv
// Purpose: Per-channel start decision, margin decode and fault latch.
// Assumes: Pin level is already synchronised; status is a fault vector.
// Notes: Polarity is captured once after reset and held until power cycles.
`default_nettype none

module pm_channel
  import pm_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic [7:0] op,
  input wire logic [7:0] cfg,
  input wire logic pin_sync,
  input wire logic [7:0] fault_in,
  input wire logic clear,
  // Results
  output logic run,
  output logic [1:0] margin_sel,
  output logic act_on_fault,
  output logic [7:0] status,
  output logic new_fault
);
  typedef struct packed {
    logic pol_taken;
    logic pol;
    logic latched_off;
    logic [7:0] status;
    logic [7:0] fault_d;
    logic run;
  } ch_s;
  ch_s st_r, st_nxt;
  logic pin_on;
  logic want;
  logic [3:0] mfield;

  always_comb begin
    st_nxt = st_r;
    mfield = op[OP_MARGIN_HI:OP_MARGIN_LO];
    margin_sel = MARGIN_OFF;
    act_on_fault = 1'b0;
    // Only the two codes of each pair are legal; anything else is off.
    case (mfield)
      MARGIN_LOW_IGN: margin_sel = MARGIN_LOW;
      MARGIN_LOW_ACT: begin
        margin_sel = MARGIN_LOW;
        act_on_fault = 1'b1;
      end
      MARGIN_HIGH_IGN: margin_sel = MARGIN_HIGH;
      MARGIN_HIGH_ACT: begin
        margin_sel = MARGIN_HIGH;
        act_on_fault = 1'b1;
      end
      default: margin_sel = MARGIN_OFF;
    endcase
    if (!st_r.pol_taken) begin
      st_nxt.pol_taken = 1'b1;
      st_nxt.pol = cfg[CFG_POL_BIT];
    end
    // Until polarity is captured the pin counts as off, so no start glitch.
    pin_on = st_r.pol_taken && (st_r.pol ? pin_sync : !pin_sync);
    if (!cfg[CFG_PU_BIT]) begin
      want = 1'b1;
    end else begin
      want = (!cfg[CFG_CMD_BIT] || op[OP_ON_BIT])
        && (!cfg[CFG_CPR_BIT] || pin_on);
    end
    st_nxt.fault_d = fault_in;
    // Set wins over clear so a lasting fault reappears at once.
    st_nxt.status = (clear ? 8'h00 : st_r.status) | fault_in;
    if (act_on_fault && |fault_in) begin
      st_nxt.latched_off = 1'b1;
    end
    if (!want) begin
      st_nxt.latched_off = 1'b0;
    end
    st_nxt.run = want && !st_nxt.latched_off;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign run = st_r.run;
  assign status = st_r.status;
  // A clear drops the sticky bits, so a lasting fault counts as new again.
  assign new_fault = |(fault_in & (clear ? 8'hff : ~st_r.status));

  chk_clear_keeps_run: assert property (
    @(posedge clk) disable iff (!rstn)
    clear && st_r.latched_off && want |=> !st_r.run)
    else $error("clear restarted a latched channel");
  chk_fault_resets: assert property (
    @(posedge clk) disable iff (!rstn)
    clear && (|fault_in) |=> (|st_r.status))
    else $error("persisting fault not set again");
endmodule : pm_channel

`default_nettype wire

// ### verilog/pm_regs.sv
// Purpose: Command register bank with paging, on/off control, guard.
// Assumes: A bus front end presents decoded command writes and reads.
// Notes: Unit-is-off lives outside the cleared status vectors.
`default_nettype none

module pm_regs
  import pm_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port from the bus front end
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  output logic [7:0] rd_data,
  output logic cmd_rejected,
  // Channel pins and faults
  input wire logic [1:0] channel_control_pin,
  input wire logic [15:0] fault_in,
  // Outputs to the power stage and margin setting inputs
  output logic [1:0] gate_enable,
  output logic [3:0] margin_sel,
  output logic [7:0] margin_target,
  input wire logic [7:0] margin_low_setting,
  input wire logic [7:0] margin_high_setting,
  output logic [1:0] unit_off,
  output logic [15:0] status,
  output logic comm_fault,
  output logic alert_n
);
  typedef struct packed {
    logic [7:0] sel;
    logic [1:0][7:0] op;
    logic [1:0][7:0] cfg;
    logic [7:0] guard;
    logic comm_fault;
    logic alert;
    logic [7:0] rd;
    logic rejected;
    logic [1:0] pin_a;
    logic [1:0] pin_b;
    logic [7:0] target;
  } regs_s;
  regs_s st_r, st_nxt;
  logic [1:0] run;
  logic [1:0] act;
  logic [1:0] clr;
  logic [1:0] nf;
  logic [1:0][1:0] msel;
  logic [1:0][7:0] stat;
  logic [1:0] tgt;
  logic allowed;
  logic wr;
  logic [7:0] gbits;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      pm_channel u_ch (
        .clk(clk),
        .rstn(rstn),
        .op(st_r.op[g]),
        .cfg(st_r.cfg[g]),
        .pin_sync(st_r.pin_b[g]),
        .fault_in(fault_in[g*8 +: 8]),
        .clear(clr[g]),
        .run(run[g]),
        .margin_sel(msel[g]),
        .act_on_fault(act[g]),
        .status(stat[g]),
        .new_fault(nf[g])
      );
      assign tgt[g] = st_r.sel[SEL_ALL_BIT] || st_r.sel[SEL_IDX_BIT] == g;
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_a = channel_control_pin;
    st_nxt.pin_b = st_r.pin_a;
    st_nxt.rejected = 1'b0;
    wr = cmd_valid && cmd_write;
    clr = 2'b00;
    gbits = cmd_data & GUARD_WRITE_MASK;
    // Guard decides per command; the guard command itself always passes.
    if (cmd_code == CMD_WRITE_GUARD) begin
      allowed = 1'b1;
    end else if (st_r.guard[GUARD_ALL_BIT]) begin
      allowed = 1'b0;
    end else if (st_r.guard[GUARD_OP_BIT]) begin
      allowed = cmd_code == CMD_CHANNEL_SELECT
        || cmd_code == CMD_OUTPUT_COMMAND;
    end else if (st_r.guard[GUARD_CFG_BIT]) begin
      allowed = cmd_code == CMD_CHANNEL_SELECT
        || cmd_code == CMD_OUTPUT_COMMAND
        || cmd_code == CMD_ON_OFF_CONFIG;
    end else begin
      allowed = 1'b1;
    end
    if (wr && !allowed) begin
      st_nxt.rejected = 1'b1;
    end else if (wr) begin
      if (cmd_code == CMD_CHANNEL_SELECT) begin
        if (!(cmd_data[SEL_ALL_BIT] && !cmd_data[SEL_IDX_BIT])) begin
          st_nxt.sel = 8'h00;
          st_nxt.sel[SEL_ALL_BIT] = cmd_data[SEL_ALL_BIT];
          st_nxt.sel[SEL_IDX_BIT] = cmd_data[SEL_IDX_BIT];
        end else begin
          st_nxt.rejected = 1'b1;
        end
      end else if (cmd_code == CMD_OUTPUT_COMMAND) begin
        for (int i = 0; i < 2; i++) begin
          if (tgt[i]) begin
            st_nxt.op[i] = cmd_data & OP_WRITE_MASK;
          end
        end
      end else if (cmd_code == CMD_ON_OFF_CONFIG) begin
        for (int i = 0; i < 2; i++) begin
          if (tgt[i]) begin
            st_nxt.cfg[i] = cmd_data & CFG_WRITE_MASK;
          end
        end
      end else if (cmd_code == CMD_CLEAR_FAULTS) begin
        clr = tgt;
        st_nxt.alert = 1'b0;
        st_nxt.comm_fault = 1'b0;
      end else if (cmd_code == CMD_WRITE_GUARD) begin
        if ((gbits & (gbits - 8'h01)) != 8'h00) begin
          st_nxt.comm_fault = 1'b1;
          st_nxt.alert = 1'b1;
          st_nxt.rejected = 1'b1;
        end else begin
          st_nxt.guard = gbits;
        end
      end else begin
        st_nxt.rejected = 1'b1;
      end
    end
    // A new fault in the same cycle as a clear still raises the alert.
    if (|nf) begin
      st_nxt.alert = 1'b1;
    end
    if (cmd_valid && !cmd_write) begin
      // Reads ignore the guard; both selected reads channel one.
      if (cmd_code == CMD_CHANNEL_SELECT) begin
        st_nxt.rd = st_r.sel;
      end else if (cmd_code == CMD_OUTPUT_COMMAND) begin
        st_nxt.rd = st_r.op[st_r.sel[SEL_ALL_BIT] ? 1'b0 :
          st_r.sel[SEL_IDX_BIT]];
      end else if (cmd_code == CMD_ON_OFF_CONFIG) begin
        st_nxt.rd = st_r.cfg[st_r.sel[SEL_ALL_BIT] ? 1'b0 :
          st_r.sel[SEL_IDX_BIT]];
      end else if (cmd_code == CMD_WRITE_GUARD) begin
        st_nxt.rd = st_r.guard;
      end else begin
        st_nxt.rd = 8'h00;
      end
    end
    st_nxt.target = margin_sel[1:0] == MARGIN_LOW ? margin_low_setting
      : margin_sel[1:0] == MARGIN_HIGH ? margin_high_setting
      : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.sel <= SEL_RESET;
      st_r.op <= {OP_RESET, OP_RESET};
      st_r.cfg <= {CFG_RESET, CFG_RESET};
      st_r.guard <= GUARD_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate_enable = run;
  assign unit_off = ~run;
  assign margin_sel = {msel[1], msel[0]};
  assign margin_target = st_r.target;
  assign status = {stat[1], stat[0]};
  assign rd_data = st_r.rd;
  assign cmd_rejected = st_r.rejected;
  assign comm_fault = st_r.comm_fault;
  assign alert_n = !st_r.alert;

  sequence s_bad_guard;
    cmd_valid && cmd_write && cmd_code == CMD_WRITE_GUARD
      && $countones(cmd_data & GUARD_WRITE_MASK) > 1;
  endsequence
  chk_guard_bad_alert: assert property (
    @(posedge clk) disable iff (!rstn)
    s_bad_guard |=> !alert_n && comm_fault)
    else $error("multi-bit guard write without alert");
  chk_guard_bad_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    s_bad_guard |=> $stable(st_r.guard))
    else $error("invalid guard write changed guard");
  chk_select_illegal: assert property (
    @(posedge clk) disable iff (!rstn)
    cmd_valid && cmd_write && cmd_code == CMD_CHANNEL_SELECT
      && cmd_data[7] && !cmd_data[0] |=> $stable(st_r.sel))
    else $error("illegal select write taken");
  chk_guard_all: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.guard[GUARD_ALL_BIT] && cmd_valid && cmd_write
      && cmd_code == CMD_OUTPUT_COMMAND |=> $stable(st_r.op))
    else $error("guarded operation write taken");
  chk_guard_op: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.guard[GUARD_OP_BIT] && cmd_valid && cmd_write
      && cmd_code == CMD_ON_OFF_CONFIG |=> $stable(st_r.cfg))
    else $error("guarded config write taken");
  chk_guard_cfg: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.guard == 8'h20 && cmd_valid && cmd_write
      && cmd_code == CMD_ON_OFF_CONFIG |=> $past(cmd_data & 8'h1e)
      == st_r.cfg[$past(st_r.sel[0])] || $past(st_r.sel[7]))
    else $error("allowed config write lost");
  chk_cfg_bit0_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    !st_r.cfg[0][0] && !st_r.cfg[1][0])
    else $error("config bit 0 not zero");
  chk_clear_alert: assert property (
    @(posedge clk) disable iff (!rstn)
    cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS && allowed
      && !(|nf) |=> alert_n)
    else $error("clear faults left alert asserted");
  chk_read_both: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.sel[7] && cmd_valid && !cmd_write
      && cmd_code == CMD_OUTPUT_COMMAND |=> rd_data == $past(st_r.op[0]))
    else $error("both-page read not channel one");
  chk_off_gates_low: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.cfg[0][4] && st_r.cfg[0][3] && !st_r.op[0][7] |=> !gate_enable[0])
    else $error("channel ran with enable clear");
endmodule : pm_regs

`default_nettype wire

// ### bench/pm_host_model.sv
// Purpose: Bus host and control pin driver facing the register bank.
// Assumes: One decoded command per request, answered one cycle later.
// Notes: Released lines show the inverse of the last byte, so a design
// that samples them late sees garbage rather than a lucky match.
`default_nettype none

module pm_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_data,
  input wire logic [7:0] rd_data,
  // Control pins
  output logic [1:0] channel_control_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'hff;
    cmd_data = 8'hff;
    channel_control_pin = 2'h0;
  end

  // Guard bytes are passed as given; a multi-bit byte is a deliberate fault.
  task automatic send(input logic w, input logic [7:0] c,
                      input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_data <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    send(1'b0, c, 8'h00);
    d = rd_data;
  endtask

  task automatic pin(input logic [1:0] v);
    @(posedge clk);
    channel_control_pin <= v;
  endtask
endmodule // pm_host_model

`default_nettype wire

// ### bench/pm_regs_tb.sv
// Purpose: Self-checking bench for the command register bank.
// Assumes: Register writes and reads answer one cycle after the request.
// Notes: Pin changes need three cycles to reach the gate outputs.
`default_nettype none

module pm_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pm_regs_pkg::*;

  localparam logic [7:0] MC [6] = '{8'h00, 8'h14, 8'h18, 8'h24, 8'h28, 8'h0c};
  localparam logic [7:0] MS [6] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h00};
  localparam logic [7:0] MT [6] = '{8'h00, 8'h3c, 8'h3c, 8'hc3, 8'hc3, 8'h00};

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_write, cmd_rejected, comm_fault, alert_n;
  logic [7:0] cmd_code, cmd_data, rd_data, margin_target;
  logic [1:0] channel_control_pin, gate_enable, unit_off;
  logic [15:0] fault_in = 16'h0000;
  logic [15:0] status;
  logic [3:0] margin_sel;
  int n_mismatch = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  pm_host_model host (.clk(clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rd_data(rd_data), .channel_control_pin(channel_control_pin));

  pm_regs uut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .rd_data(rd_data), .cmd_rejected(cmd_rejected),
    .channel_control_pin(channel_control_pin), .fault_in(fault_in),
    .gate_enable(gate_enable), .margin_sel(margin_sel),
    .margin_target(margin_target), .margin_low_setting(8'h3c),
    .margin_high_setting(8'hc3), .unit_off(unit_off), .status(status),
    .comm_fault(comm_fault), .alert_n(alert_n));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d,
                    input logic rej);
    host.send(1'b1, c, d);
    chk(8'(cmd_rejected), 8'(rej));
  endtask

  task automatic rdc(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(c, v);
    chk(v, exp);
  endtask

  task automatic t_reset;
    rdc(CMD_ON_OFF_CONFIG, 8'h16);
    rdc(CMD_OUTPUT_COMMAND, 8'h00);
    rdc(CMD_WRITE_GUARD, 8'h00);
    rdc(CMD_CHANNEL_SELECT, 8'h00);
    chk(8'(unit_off), 8'h03);
    chk(8'(alert_n), 8'h01);
  endtask

  task automatic t_page;
    wr(CMD_CHANNEL_SELECT, 8'h01, 1'b0);
    wr(CMD_CHANNEL_SELECT, 8'h80, 1'b1);
    rdc(CMD_CHANNEL_SELECT, 8'h01);
    wr(CMD_OUTPUT_COMMAND, 8'h14, 1'b0);
    chk(8'(margin_sel[3:2]), 8'h01);
    wr(CMD_ON_OFF_CONFIG, 8'h02, 1'b0);
    w(3);
    chk(8'(gate_enable), 8'h02);
    wr(CMD_CHANNEL_SELECT, 8'h81, 1'b0);
    rdc(CMD_ON_OFF_CONFIG, 8'h16);
    rdc(CMD_OUTPUT_COMMAND, 8'h00);
    wr(CMD_CHANNEL_SELECT, 8'h00, 1'b0);
  endtask

  task automatic t_onoff;
    wr(CMD_ON_OFF_CONFIG, 8'hff, 1'b0);
    rdc(CMD_ON_OFF_CONFIG, 8'h1e);
    wr(CMD_OUTPUT_COMMAND, 8'hff, 1'b0);
    rdc(CMD_OUTPUT_COMMAND, 8'hbc);
    w(3);
    chk(8'(gate_enable[0]), 8'h00);
    host.pin(2'h1);
    w(4);
    chk(8'(gate_enable[0]), 8'h01);
    wr(CMD_ON_OFF_CONFIG, 8'h1a, 1'b0);
    wr(CMD_OUTPUT_COMMAND, 8'h00, 1'b0);
    w(3);
    chk(8'(gate_enable[0]), 8'h00);
    wr(CMD_ON_OFF_CONFIG, 8'h14, 1'b0);
    w(3);
    chk(8'(gate_enable[0]), 8'h01);
    host.pin(2'h0);
    w(4);
    chk(8'(gate_enable[0]), 8'h00);
  endtask

  task automatic t_margin;
    for (int i = 0; i < 6; i++) begin
      wr(CMD_OUTPUT_COMMAND, MC[i], 1'b0);
      w(2);
      chk(8'(margin_sel[1:0]), MS[i]);
      chk(margin_target, MT[i]);
    end
  endtask

  task automatic t_guard;
    wr(CMD_WRITE_GUARD, 8'h20, 1'b0);
    wr(CMD_ON_OFF_CONFIG, 8'h16, 1'b0);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    wr(CMD_WRITE_GUARD, 8'h40, 1'b0);
    wr(CMD_ON_OFF_CONFIG, 8'h1e, 1'b1);
    wr(CMD_OUTPUT_COMMAND, 8'h00, 1'b0);
    wr(CMD_WRITE_GUARD, 8'h80, 1'b0);
    wr(CMD_CHANNEL_SELECT, 8'h01, 1'b1);
    wr(CMD_OUTPUT_COMMAND, 8'h80, 1'b1);
    rdc(CMD_CHANNEL_SELECT, 8'h00);
    rdc(CMD_ON_OFF_CONFIG, 8'h16);
    wr(CMD_WRITE_GUARD, 8'h60, 1'b1);
    rdc(CMD_WRITE_GUARD, 8'h80);
    chk(8'(comm_fault), 8'h01);
    chk(8'(alert_n), 8'h00);
    wr(CMD_WRITE_GUARD, 8'h00, 1'b0);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    w(1);
    chk(8'(alert_n), 8'h01);
  endtask

  task automatic t_fault;
    wr(CMD_ON_OFF_CONFIG, 8'h1a, 1'b0);
    wr(CMD_OUTPUT_COMMAND, 8'ha8, 1'b0);
    w(3);
    chk(8'(gate_enable[0]), 8'h01);
    @(posedge clk);
    fault_in <= 16'h0001;
    w(3);
    chk(status[7:0], 8'h01);
    chk(8'(gate_enable[0]), 8'h00);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    w(2);
    chk(status[7:0], 8'h01);
    chk(8'(alert_n), 8'h00);
    @(posedge clk);
    fault_in <= 16'h0000;
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b0);
    w(2);
    chk(status[7:0], 8'h00);
    chk(8'(alert_n), 8'h01);
    chk(8'(gate_enable[0]), 8'h00);
    chk(8'(unit_off[0]), 8'h01);
  endtask

  // Whole run needs about 140 cycles; this leaves ample margin.
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_page();
    t_onoff();
    t_margin();
    t_guard();
    t_fault();
    end_of_test();
  end
endmodule // pm_regs_tb

`default_nettype wire
